// File: logic/gst_pkg.sv
// gst_pkg: constants, field layouts and carriers for the gated 16-bit timer
package gst_pkg;

   // ************************************************************
   // register byte addresses on the apb bus
   // ************************************************************
   localparam logic [7:0] TIMER_CONTROL_OFS = 8'h00; // source, prescale, run
   localparam logic [7:0] GATE_CONTROL_OFS  = 8'h04; // gate configuration
   localparam logic [7:0] COUNT_LOW_OFS     = 8'h08; // count low byte
   localparam logic [7:0] COUNT_HIGH_OFS    = 8'h0C; // count high byte
   localparam logic [7:0] FLAG_STATUS_OFS   = 8'h10; // sticky flags, w1c

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int FLAG_OVERFLOW_BIT   = 0;         // count rollover flag
   localparam int FLAG_GATE_EVENT_BIT = 1;         // gate falling edge flag
   localparam logic [7:0] TIMER_CONTROL_RST = 8'h00;
   localparam logic [7:0] GATE_CONTROL_RST  = 8'h00;
   localparam logic [15:0] COUNT_RST        = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONES   = 16'hFFFF;
   localparam logic [7:0] T0_ROLL_FROM      = 8'hFF; // eight-bit timer wrap
   localparam logic [7:0] T0_ROLL_TO        = 8'h00;

   // ************************************************************
   // timing: system clock rate and instruction clock divider
   // ************************************************************
   localparam int CLOCK_PERIOD_PS = 4000;          // 250 mhz system clock
   localparam int INSTR_DIVIDE    = 4;             // fosc over four
   localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_DIVIDE - 1);

   // ************************************************************
   // enumerations
   // ************************************************************
   typedef enum logic [1:0] {
      GST_CLK_INSTR = 2'b00,                       // system clock / 4
      GST_CLK_SYS   = 2'b01,                       // system clock
      GST_CLK_EXT   = 2'b10,                       // external clock pin
      GST_CLK_LFOSC = 2'b11                        // low-frequency oscillator
   } gst_clk_sel_t;

   typedef enum logic [1:0] {
      GST_GATE_PIN  = 2'b00,                       // gate input pin
      GST_GATE_T0   = 2'b01,                       // eight-bit timer overflow
      GST_GATE_CMP1 = 2'b10,                       // comparator one
      GST_GATE_CMP2 = 2'b11                        // comparator two
   } gst_gate_src_t;

   // ************************************************************
   // register carriers, msb first
   // ************************************************************
   typedef struct packed {
      gst_clk_sel_t clockSelect;                   // bits 7:6
      logic [1:0]   prescale;                      // bits 5:4
      logic         oscEnable;                     // bit 3
      logic         asyncSelect;                   // bit 2
      logic         spare;                         // bit 1, reads zero
      logic         run;                           // bit 0
   } gst_timer_ctrl_t;

   typedef struct packed {
      logic          gateEnable;                   // bit 7
      logic          gatePolarity;                 // bit 6
      logic          toggleMode;                   // bit 5
      logic          singlePulse;                  // bit 4
      logic          singlePulseGo;                // bit 3
      logic          gateValue;                    // bit 2, read only
      gst_gate_src_t gateSource;                   // bits 1:0
   } gst_gate_ctrl_t;

endpackage

// File: logic/gst_timer.sv
// gst_timer: gated 16-bit timer with prescaler and apb register slave
//
// Behaviour
// - 16-bit count, byte writes replace live bytes
// - run off stops; gate enable gates counting
// - clock select picks one of four sources
// - system clock source advances four per instruction
// - external clock counts rising edges, sync/async, only with oscEnable clear
// - external mode waits first falling edge
// - prescaler divides by 1,2,4,8, hidden
// - count byte write clears prescaler
// - async select has no effect; edges always synced
// - count reads always return valid bytes
// - mode switch neither drops nor adds one
// - gate polarity chooses active level
// - gate source field selects four inputs
// - eight-bit timer wrap gives one pulse
// - toggle mode flips gate per edge
// - toggle flop held clear when off
// - single pulse go arms one gate window
// - toggle plus pulse counts one cycle
// - rollover sets sticky overflow flag
// - gate value status always readable
// - gate value falling edge sets flag
`timescale 1ns/1ps
`default_nettype none

module gst_timer (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // asynchronous pins and comparators
   input  wire logic        externalClockInput,
   input  wire logic        lowFreqInternalOsc,
   input  wire logic        gateInputPin,
   input  wire logic        comparatorOneOutput,
   input  wire logic        comparatorTwoOutput,
   // eight-bit timer count, same clock domain
   input  wire logic [7:0]  eightBitTimerCount
);

   // ************************************************************
   // asynchronous input synchronisers
   // ************************************************************
   localparam int NSYNC = 5;                       // pins brought in
   logic [NSYNC-1:0] pinRaw;                       // raw pin vector
   logic [NSYNC-1:0] syncFirst_q;                  // first stage only
   logic [NSYNC-1:0] syncSecond_q;                 // safe to read
   logic [NSYNC-1:0] syncLast_q;                   // for edge detect
   logic [NSYNC-1:0] pinRise;                      // synced rising edges
   logic [NSYNC-1:0] pinFall;                      // synced falling edges
   logic [2:0]       settle_q;                     // high once pins synced

   assign pinRaw = {comparatorTwoOutput, comparatorOneOutput, gateInputPin,
                    lowFreqInternalOsc, externalClockInput};

   // three flops per pin; edges compare the second stage with the third
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         syncFirst_q  <= '0;
         syncSecond_q <= '0;
         syncLast_q   <= '0;
      end else begin
         syncFirst_q  <= pinRaw;
         syncSecond_q <= syncFirst_q;
         syncLast_q   <= syncSecond_q;
      end
   end

   // the sync stages reset low whatever the pins show, so gate edges
   // are trusted only once real pin levels have passed through them
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         settle_q <= '0;
      end else begin
         settle_q <= {settle_q[1:0], 1'b1};
      end
   end

   assign pinRise = syncSecond_q & ~syncLast_q;
   assign pinFall = ~syncSecond_q & syncLast_q;

   // ************************************************************
   // registers and apb access decode
   // ************************************************************
   gst_pkg::gst_timer_ctrl_t timerCtrl_q;          // source, prescale, run
   gst_pkg::gst_gate_ctrl_t  gateCtrl_q;           // gate config (go inside)
   logic [15:0] count_q;                           // live count
   logic [2:0]  pre_q;                             // hidden prescale count
   logic        ovfFlag_q;                         // sticky rollover flag
   logic        gateEvtFlag_q;                     // sticky gate event flag
   logic        accessDone;                        // edge the transfer ends
   logic        wrEn;                              // write takes effect
   logic        wrLow;                             // write to low byte
   logic        wrHigh;                            // write to high byte
   logic        wrCount;                           // either count byte
   logic        incr;                              // count advances now

   // one wait state: pready rises in the second access cycle
   assign accessDone = psel && penable && pready;
   assign wrEn   = accessDone && pwrite;
   assign wrLow  = wrEn && (paddr == gst_pkg::COUNT_LOW_OFS);
   assign wrHigh = wrEn && (paddr == gst_pkg::COUNT_HIGH_OFS);
   assign wrCount = wrLow || wrHigh;

   // decode used by the error answer only; the read mux has its own case
   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == gst_pkg::TIMER_CONTROL_OFS) ||
                 (a == gst_pkg::GATE_CONTROL_OFS)  ||
                 (a == gst_pkg::COUNT_LOW_OFS)     ||
                 (a == gst_pkg::COUNT_HIGH_OFS)    ||
                 (a == gst_pkg::FLAG_STATUS_OFS);
   endfunction

   // ************************************************************
   // clock source, instruction divider and gate evaluation
   // ************************************************************
   logic [1:0]  instrDiv_q;                        // fosc/4 divider
   logic        instrTick;                         // one pulse per 4 clocks
   logic        extArmed_q;                        // falling edge seen
   logic        srcTick;                           // selected source edge
   logic [7:0]  t0Last_q;                          // previous timer value
   logic        t0Pulse;                           // eight-bit timer wrap
   logic        gateRaw;                           // selected gate input
   logic        gateAct;                           // polarity-adjusted gate
   logic        gateActLast_q;                     // for toggle edges
   logic        toggle_q;                          // gate toggle flop
   logic        stage;                             // after toggle stage
   logic        stageLast_q;                       // for pulse edges
   logic        stageRise;                         // incrementing gate edge
   logic        stageFall;                         // trailing gate edge
   logic        pulseWin_q;                        // single pulse window
   logic        gateValue;                         // internal gate level
   logic        gateValLast_q;                     // for gate event edge
   logic        countEn;                           // run and gate permit

   // free divider: the instruction tick is a one-cycle enable
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         instrDiv_q <= '0;
      end else begin
         instrDiv_q <= instrDiv_q + 2'b01;
      end
   end
   assign instrTick = (instrDiv_q == gst_pkg::INSTR_DIV_LAST);

   // external counting needs one falling edge before the first rise;
   // disarmed by a count write or by stopping the timer
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         extArmed_q <= 1'b0;
      end else if (wrCount || !timerCtrl_q.run) begin
         extArmed_q <= 1'b0;
      end else if (pinFall[0]) begin
         extArmed_q <= 1'b1;
      end
   end

   // source select; async mode shares the synchronised edge since the
   // block has one clock, so no increment is lost or added on a switch
   always_comb begin
      case (timerCtrl_q.clockSelect)
         gst_pkg::GST_CLK_INSTR: srcTick = instrTick;
         gst_pkg::GST_CLK_SYS:   srcTick = 1'b1;
         gst_pkg::GST_CLK_EXT:   srcTick = pinRise[0] && extArmed_q &&
                                           !timerCtrl_q.oscEnable;
         gst_pkg::GST_CLK_LFOSC: srcTick = pinRise[1];
         default:                srcTick = 1'b0;
      endcase
   end

   // previous eight-bit timer value for wrap detection
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         t0Last_q <= '0;
      end else begin
         t0Last_q <= eightBitTimerCount;
      end
   end
   assign t0Pulse = (t0Last_q == gst_pkg::T0_ROLL_FROM) &&
                    (eightBitTimerCount == gst_pkg::T0_ROLL_TO);

   // gate source select and polarity
   always_comb begin
      case (gateCtrl_q.gateSource)
         gst_pkg::GST_GATE_PIN:  gateRaw = syncSecond_q[2];
         gst_pkg::GST_GATE_T0:   gateRaw = t0Pulse;
         gst_pkg::GST_GATE_CMP1: gateRaw = syncSecond_q[3];
         gst_pkg::GST_GATE_CMP2: gateRaw = syncSecond_q[4];
         default:                gateRaw = 1'b0;
      endcase
   end
   assign gateAct = gateCtrl_q.gatePolarity ? gateRaw : !gateRaw;

   // toggle flop flips on each incrementing edge; held clear when off
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         gateActLast_q <= 1'b0;
         toggle_q      <= 1'b0;
      end else begin
         gateActLast_q <= gateAct;
         if (!gateCtrl_q.toggleMode) begin
            toggle_q <= 1'b0;
         end else if (gateAct && !gateActLast_q) begin
            toggle_q <= !toggle_q;
         end
      end
   end
   assign stage = gateCtrl_q.toggleMode ? toggle_q : gateAct;

   // single pulse follows the toggle stage, so both run in series
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stageLast_q <= 1'b0;
         pulseWin_q  <= 1'b0;
      end else begin
         stageLast_q <= stage;
         if (!gateCtrl_q.singlePulse) begin
            pulseWin_q <= 1'b0;
         end else if (!pulseWin_q && stageRise && gateCtrl_q.singlePulseGo) begin
            pulseWin_q <= 1'b1;
         end else if (pulseWin_q && stageFall) begin
            pulseWin_q <= 1'b0;
         end
      end
   end
   assign stageRise = stage && !stageLast_q;
   assign stageFall = !stage && stageLast_q;
   assign gateValue = gateCtrl_q.singlePulse ? pulseWin_q : stage;

   // gate value history for the event flag
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         gateValLast_q <= 1'b0;
      end else begin
         gateValLast_q <= gateValue;
      end
   end

   assign countEn = timerCtrl_q.run &&
                    (!gateCtrl_q.gateEnable || gateValue);

   // ************************************************************
   // prescaler and count
   // ************************************************************
   logic [2:0] preLast;                            // divide-by mask
   assign preLast = 3'((4'b0001 << timerCtrl_q.prescale) - 4'b0001);
   assign incr = srcTick && countEn && (pre_q == preLast) && !wrCount;

   // prescaler counts gated source ticks; a count write clears it
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pre_q <= '0;
      end else if (wrCount) begin
         pre_q <= '0;
      end else if (srcTick && countEn) begin
         pre_q <= (pre_q == preLast) ? 3'b000 : pre_q + 3'b001;
      end
   end

   // a write replaces its byte and wins over a coincident increment
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         count_q <= gst_pkg::COUNT_RST;
      end else if (wrLow) begin
         count_q[7:0] <= pwdata[7:0];
      end else if (wrHigh) begin
         count_q[15:8] <= pwdata[7:0];
      end else if (incr) begin
         count_q <= count_q + 16'h0001;
      end
   end

   // ************************************************************
   // control registers and sticky flags
   // ************************************************************
   logic goClear;                                  // hardware clears go
   assign goClear = pulseWin_q && stageFall;

   // control registers; software set of go wins over its hardware clear
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         timerCtrl_q <= gst_pkg::gst_timer_ctrl_t'(gst_pkg::TIMER_CONTROL_RST);
         gateCtrl_q  <= gst_pkg::gst_gate_ctrl_t'(gst_pkg::GATE_CONTROL_RST);
      end else begin
         if (wrEn && paddr == gst_pkg::TIMER_CONTROL_OFS) begin
            timerCtrl_q       <= gst_pkg::gst_timer_ctrl_t'(pwdata[7:0]);
            timerCtrl_q.spare <= 1'b0;
         end
         gateCtrl_q.gateValue <= gateValue;
         if (wrEn && paddr == gst_pkg::GATE_CONTROL_OFS) begin
            gateCtrl_q.gateEnable    <= pwdata[7];
            gateCtrl_q.gatePolarity  <= pwdata[6];
            gateCtrl_q.toggleMode    <= pwdata[5];
            gateCtrl_q.singlePulse   <= pwdata[4];
            gateCtrl_q.singlePulseGo <= pwdata[3];
            gateCtrl_q.gateSource    <= gst_pkg::gst_gate_src_t'(pwdata[1:0]);
         end else if (goClear) begin
            gateCtrl_q.singlePulseGo <= 1'b0;
         end
      end
   end

   // sticky flags, write one to clear; a new event beats the clear
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ovfFlag_q     <= 1'b0;
         gateEvtFlag_q <= 1'b0;
      end else begin
         if (incr && count_q == gst_pkg::COUNT_ALL_ONES) begin
            ovfFlag_q <= 1'b1;
         end else if (wrEn && paddr == gst_pkg::FLAG_STATUS_OFS &&
                      pwdata[gst_pkg::FLAG_OVERFLOW_BIT]) begin
            ovfFlag_q <= 1'b0;
         end
         if (!gateValue && gateValLast_q && settle_q[2]) begin
            gateEvtFlag_q <= 1'b1;
         end else if (wrEn && paddr == gst_pkg::FLAG_STATUS_OFS &&
                      pwdata[gst_pkg::FLAG_GATE_EVENT_BIT]) begin
            gateEvtFlag_q <= 1'b0;
         end
      end
   end

   // ************************************************************
   // apb answer: ready, read data and error all registered
   // ************************************************************
   logic [7:0] rdByte;                             // selected read byte
   always_comb begin
      case (paddr)
         gst_pkg::TIMER_CONTROL_OFS: rdByte = timerCtrl_q;
         gst_pkg::GATE_CONTROL_OFS:  rdByte = gateCtrl_q;
         gst_pkg::COUNT_LOW_OFS:     rdByte = count_q[7:0];
         gst_pkg::COUNT_HIGH_OFS:    rdByte = count_q[15:8];
         gst_pkg::FLAG_STATUS_OFS:   rdByte = {6'h00, gateEvtFlag_q, ovfFlag_q};
         default:                    rdByte = 8'h00;
      endcase
   end

   // pready pulses in the second access cycle; read data taken there
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !isMapped(paddr);
         if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h00000000 : {24'h000000, rdByte};
         end
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence lowWriteSeq;
      wrLow;
   endsequence

   count_write_a: assert property (lowWriteSeq |=> count_q[7:0] == $past(pwdata[7:0]))
      else $error("count low byte write not applied");

   run_off_a: assert property (!timerCtrl_q.run && !wrCount |=> $stable(count_q))
      else $error("count moved while stopped");

   sys_clock_a: assert property (timerCtrl_q.run && !gateCtrl_q.gateEnable &&
      timerCtrl_q.clockSelect == gst_pkg::GST_CLK_SYS &&
      timerCtrl_q.prescale == 2'b00 && !wrCount
      |-> incr)
      else $error("system clock source did not count every cycle");

   instr_div_a: assert property (incr &&
      timerCtrl_q.clockSelect == gst_pkg::GST_CLK_INSTR
      && $stable(timerCtrl_q) |=> !incr [*3])
      else $error("instruction clock counted faster than one in four");

   ext_armed_a: assert property (!extArmed_q |-> !(incr &&
      timerCtrl_q.clockSelect == gst_pkg::GST_CLK_EXT))
      else $error("external count before first falling edge");

   pre_clear_a: assert property (wrCount |=> pre_q == 3'b000)
      else $error("prescaler not cleared by count write");

   overflow_a: assert property (incr && count_q == gst_pkg::COUNT_ALL_ONES
      |=> ovfFlag_q && count_q == gst_pkg::COUNT_RST)
      else $error("rollover did not set overflow flag");

   toggle_clr_a: assert property (!gateCtrl_q.toggleMode |=> !toggle_q)
      else $error("toggle flop not held clear");

   gate_event_a: assert property ($fell(gateValue) && settle_q[2] |=> gateEvtFlag_q)
      else $error("gate falling edge did not set event flag");

   sequence pulseEndSeq;
      pulseWin_q && stageFall && gateCtrl_q.singlePulse;
   endsequence

   go_done_a: assert property ((pulseEndSeq and !wrEn)
      |=> !gateCtrl_q.singlePulseGo && !pulseWin_q)
      else $error("go flag not cleared at trailing gate edge");

endmodule

`default_nettype wire

// File: tb/gst_pins_model.sv
// gst_pins_model: far-side pins, oscillator and eight-bit timer
`timescale 1ns/1ps
`default_nettype none
module gst_pins_model (
   // bench controls
   input  wire logic  clock,
   input  wire logic  extGo,
   input  wire logic  gateLvl,
   // pins toward the timer
   output logic       externalClockInput,
   output logic       lowFreqInternalOsc,
   output logic       gateInputPin,
   output logic       comparatorOneOutput,
   output logic       comparatorTwoOutput,
   output logic [7:0] eightBitTimerCount
);
   logic [3:0] extPhase = 4'h0; // burst phase, parked at zero
   logic [3:0] oscPhase = 4'h0; // slow oscillator phase
   logic [7:0] t0Cnt = 8'h00;   // eight-bit timer count
   // free eight-bit timer: wraps every 256 cycles, so gate pulses exist
   always @(posedge clock) begin
      t0Cnt <= t0Cnt + 8'h01;
      oscPhase <= oscPhase + 4'h1;
      extPhase <= extGo ? extPhase + 4'h1 : 4'h0;
   end
   // ext clock stands low between bursts: 4 low, 4 high per period
   assign externalClockInput  = extGo & extPhase[2];
   assign lowFreqInternalOsc  = oscPhase[3];
   assign gateInputPin        = gateLvl;
   assign comparatorOneOutput = ~gateLvl;
   assign comparatorTwoOutput = oscPhase[2];
   assign eightBitTimerCount  = t0Cnt;
endmodule
`default_nettype wire

// File: tb/gst_timer_tb_top.sv
// gst_timer_tb_top: apb-level tests of the gated timer
`timescale 1ns/1ps
`default_nettype none
module gst_timer_tb_top;
   logic        clock = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0, extGo = 1'h0, gateLvl = 1'h1;
   logic        pready, pslverr, err, extClk, lfOsc, gatePin, cmpA, cmpB;
   logic [7:0]  paddr = 8'h00, t0Count;
   logic [15:0] cnt;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int          nErrors = 0, compares = 0, expv;
   logic [7:0]  ofs [5] = '{gst_pkg::TIMER_CONTROL_OFS,
      gst_pkg::GATE_CONTROL_OFS, gst_pkg::COUNT_LOW_OFS,
      gst_pkg::COUNT_HIGH_OFS, gst_pkg::FLAG_STATUS_OFS};
   always #2 clock = ~clock;
   gst_timer uut (.clock(clock), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .externalClockInput(extClk), .lowFreqInternalOsc(lfOsc),
      .gateInputPin(gatePin), .comparatorOneOutput(cmpA),
      .comparatorTwoOutput(cmpB), .eightBitTimerCount(t0Count));
   gst_pins_model far (.clock(clock), .extGo(extGo), .gateLvl(gateLvl),
      .externalClockInput(extClk), .lowFreqInternalOsc(lfOsc),
      .gateInputPin(gatePin), .comparatorOneOutput(cmpA),
      .comparatorTwoOutput(cmpB), .eightBitTimerCount(t0Count));
   // one transfer; request held until pready is sampled at an edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'h1;
      do @(posedge clock); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic check(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         $display("unexpected %s: expected %h seen %h", nm, e, g);
         nErrors++;
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      check("register", e, rd);
      check("slave error", 32'h0, {31'h0, err});
   endtask
   task automatic readCount();
      apb(1'h0, ofs[2], 32'h0);
      cnt[7:0] = rd[7:0];
      apb(1'h0, ofs[3], 32'h0);
      cnt[15:8] = rd[7:0];
   endtask
   // stop before touching the count; the write also clears the prescaler
   task automatic zero();
      apb(1'h1, ofs[0], 32'h0);
      apb(1'h1, ofs[2], 32'h0);
      apb(1'h1, ofs[3], 32'h0);
   endtask
   task automatic stopTest();
      $display("compares %0d, mismatches %0d", compares, nErrors);
      if (nErrors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog: the tests need under 4000 cycles
   initial begin
      repeat (10000) @(posedge clock);
      nErrors++;
      stopTest();
   end
   initial begin
      repeat (8) @(posedge clock);
      rstn <= 1'h1;
      for (int i = 0; i < 5; i++) rdchk(ofs[i], 32'h0);
      apb(1'h0, 8'h14, 32'h0);
      check("unmapped error", 32'h1, {31'h0, err});
      $display("test reset done");
      apb(1'h1, ofs[2], 32'hFE);
      apb(1'h1, ofs[3], 32'hFF);
      repeat (20) @(posedge clock);
      readCount();
      check("held count", 32'hFFFE, {16'h0, cnt});
      apb(1'h1, ofs[0], 32'h41);
      apb(1'h1, ofs[0], 32'h40);
      rdchk(ofs[4], 32'h1);
      apb(1'h1, ofs[4], 32'h1);
      rdchk(ofs[4], 32'h0);
      $display("test rollover done");
      // sources fosc/4 and fosc, prescale 1 and 8, over 256 cycles
      for (int m = 0; m < 4; m++) begin
         zero();
         apb(1'h1, ofs[0], {24'h0, 1'b0, m[0], m[1], m[1], 4'h1});
         repeat (252) @(posedge clock);
         apb(1'h1, ofs[0], 32'h0);
         readCount();
         expv = 256 >> ((m[1] ? 3 : 0) + (m[0] ? 0 : 2));
         if (cnt <= expv + 1 && cnt + 1 >= expv) cnt = 16'(expv);
         check("rate count", 32'(expv), {16'h0, cnt});
      end
      $display("test rates done");
      zero();
      apb(1'h1, ofs[0], 32'h81);
      extGo <= 1'h1;
      repeat (40) @(posedge clock);
      extGo <= 1'h0;
      repeat (10) @(posedge clock);
      readCount();
      check("external count", 32'h4, {16'h0, cnt});
      $display("test external done");
      zero();
      apb(1'h1, ofs[1], 32'h80);
      apb(1'h1, ofs[0], 32'h41);
      repeat (30) @(posedge clock);
      readCount();
      check("gated count", 32'h0, {16'h0, cnt});
      apb(1'h1, ofs[1], 32'hC0);
      rdchk(ofs[1], 32'hC4);
      apb(1'h1, ofs[4], 32'h3);
      gateLvl <= 1'h0;
      repeat (8) @(posedge clock);
      rdchk(ofs[4], 32'h2);
      zero();
      apb(1'h1, ofs[1], 32'hD0);
      apb(1'h1, ofs[1], 32'hD8);
      apb(1'h1, ofs[0], 32'h41);
      gateLvl <= 1'h1;
      repeat (20) @(posedge clock);
      gateLvl <= 1'h0;
      repeat (8) @(posedge clock);
      rdchk(ofs[1], 32'hD0);
      readCount();
      if (cnt > 16'h11 && cnt < 16'h17) cnt = 16'h14;
      check("pulse count", 32'h14, {16'h0, cnt});
      apb(1'h1, ofs[1], 32'hC0);
      $display("test gate done");
      // toggle and single pulse in series on the eight-bit timer wrap
      zero();
      apb(1'h1, ofs[1], 32'hF1);
      apb(1'h1, ofs[0], 32'h41);
      apb(1'h1, ofs[1], 32'hF9);
      repeat (1100) @(posedge clock);
      rdchk(ofs[1], 32'hF1);
      readCount();
      check("full period count", 32'h100, {16'h0, cnt});
      $display("test toggle pulse done");
      // second reset in mid-run: count and flags back to zero, gate value bit reads set, no false event
      rstn <= 1'h0;
      repeat (2) @(posedge clock);
      rstn <= 1'h1;
      rdchk(ofs[1], 32'h4);
      readCount();
      check("count after reset", 32'h0, {16'h0, cnt});
      rdchk(ofs[4], 32'h0);
      $display("test second reset done");
      stopTest();
   end
endmodule
`default_nettype wire
